// ---- src/pio_map.vh ----
// pio_map.vh: port widths and reset values for the parallel i/o block
// assumes: included by the pio design files only
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
`define PIO_WIDE_W 8
`define PIO_NARROW_W 3
`define PIO_WIDE_RST 8'h00
`define PIO_NARROW_RST 3'h0
// legacy mode: bits 2:1 output, bit 0 input
`define PIO_LEGACY_DIR 3'h6
`define PIO_LEGACY_DIR_MASK 3'h7
// external reset filter: minimum low time and cycle count
`define PIO_RST_MIN_NS 1500
`define PIO_CLK_NS 40
// 1500 ns at a 40 ns clock, rounded up
`define PIO_RST_MIN_CYC 6'h26
`define PIO_RST_CNT_W 6
`endif

// ---- src/pio_pin_bank.v ----
// pio_pin_bank.v: one bank of bidirectional pins with per-bit pull-ups
// assumes: asynchronous active-high reset from the top, pins resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.vh"
module pio_pin_bank #(
	parameter W = 8
) (
	// clock and reset
	input wire i_mclk,
	input wire i_rst,
	// core side
	input wire i_wr,
	input wire [W-1:0] i_dir,
	input wire [W-1:0] i_out,
	input wire [W-1:0] i_pull,
	input wire [W-1:0] i_force_mask,
	input wire [W-1:0] i_force_dir,
	output reg [W-1:0] o_in,
	// pin side
	input wire [W-1:0] i_pin,
	output reg [W-1:0] o_pin,
	output reg [W-1:0] o_pin_oe,
	output reg [W-1:0] o_pull_en
);
	reg [W-1:0] dir_reg;
	reg [W-1:0] out_reg;
	reg [W-1:0] pull_reg;
	reg [W-1:0] sync1_reg;
	genvar b;
	// ==========================================
	// per-bit control
	generate
		for (b = 0; b < W; b = b + 1) begin : g_bit
			wire dir_eff;
			assign dir_eff = i_force_mask[b] ? i_force_dir[b] : dir_reg[b];
			always @(posedge i_mclk or posedge i_rst) begin
				if (i_rst) begin
					dir_reg[b] <= 1'b0;
					out_reg[b] <= 1'b0;
					pull_reg[b] <= 1'b0;
					o_pin[b] <= 1'b0;
					o_pin_oe[b] <= 1'b0;
					o_pull_en[b] <= 1'b0;
					sync1_reg[b] <= 1'b0;
					o_in[b] <= 1'b0;
				end else begin
					if (i_wr) begin
						dir_reg[b] <= i_dir[b];
						out_reg[b] <= i_out[b];
						pull_reg[b] <= i_pull[b];
					end
					o_pin[b] <= out_reg[b];
					o_pin_oe[b] <= dir_eff;
					// pull-up only on inputs driven high
					o_pull_en[b] <= ~dir_eff & out_reg[b] & pull_reg[b];
					sync1_reg[b] <= i_pin[b];
					o_in[b] <= sync1_reg[b];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- src/pio_top.v ----
// pio_top.v: four 8-bit ports and one 3-bit port, pins and core side
// assumes: core writes settings per port; board resolves pins from oe
// Notes on behaviour
// - four eight-bit ports, each pin separately input or output
// - one three-bit port with the same per-pin direction control
// - each pin has its own pull-up, enabled only while it is an input with its output bit high
// - any reset tri-states all pins at once, no clock needed
// - external low reset past minimum length resets, even without clock
// - legacy fuse forces narrow port bits 2:1 out, bit 0 in
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.vh"
module pio_top (
	// clock and reset
	input wire i_mclk,
	input wire i_rst,
	input wire i_ext_rst_n,
	input wire i_legacy_compat_fuse,
	// core write strobes, one per port
	input wire [4:0] i_port_wr,
	input wire [`PIO_WIDE_W*4-1:0] i_wide_dir,
	input wire [`PIO_WIDE_W*4-1:0] i_wide_out,
	input wire [`PIO_WIDE_W*4-1:0] i_wide_pull,
	input wire [`PIO_NARROW_W-1:0] i_narrow_dir,
	input wire [`PIO_NARROW_W-1:0] i_narrow_port_output,
	input wire [`PIO_NARROW_W-1:0] i_narrow_pull,
	// core read side
	output wire [`PIO_WIDE_W*4-1:0] o_wide_in,
	output wire [`PIO_NARROW_W-1:0] o_narrow_in,
	output reg o_rst_active,
	// pins
	input wire [`PIO_WIDE_W-1:0] i_port_one_pins,
	input wire [`PIO_WIDE_W-1:0] i_port_two_pins,
	input wire [`PIO_WIDE_W-1:0] i_port_three_pins,
	input wire [`PIO_WIDE_W-1:0] i_port_four_pins,
	input wire [`PIO_NARROW_W-1:0] i_narrow_port_pins,
	output wire [`PIO_WIDE_W*4-1:0] o_wide_pins,
	output wire [`PIO_WIDE_W*4-1:0] o_wide_pins_oe,
	output wire [`PIO_WIDE_W*4-1:0] o_wide_pull_en,
	output wire [`PIO_NARROW_W-1:0] o_narrow_port_pins,
	output wire [`PIO_NARROW_W-1:0] o_narrow_port_pins_oe,
	output wire [`PIO_NARROW_W-1:0] o_narrow_pull_en
);
	// ==========================================
	// external reset: async assert, filtered release
	localparam [1:0] RF_IDLE = 2'b00;
	localparam [1:0] RF_COUNT = 2'b01;
	localparam [1:0] RF_HOLD = 2'b10;
	reg [1:0] rf_state_reg;
	reg [1:0] rf_state_next;
	reg [`PIO_RST_CNT_W-1:0] low_cnt_reg;
	reg [`PIO_RST_CNT_W-1:0] low_cnt_next;
	reg ext_s1_reg;
	reg ext_s2_reg;
	reg ext_hold_reg;
	reg ext_hold_next;
	wire [`PIO_RST_CNT_W-1:0] rst_min_cyc;
	wire ext_low;
	wire bank_rst;
	assign rst_min_cyc = `PIO_RST_MIN_CYC;
	assign ext_low = ~ext_s2_reg;

	// ==========================================
	// pin synchroniser, two flops
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ext_s1_reg <= 1'b1;
			ext_s2_reg <= 1'b1;
		end else begin
			ext_s1_reg <= i_ext_rst_n;
			ext_s2_reg <= ext_s1_reg;
		end
	end

	// ==========================================
	// low-time filter, next state
	always @* begin
		rf_state_next = rf_state_reg;
		low_cnt_next = low_cnt_reg;
		ext_hold_next = ext_hold_reg;
		case (rf_state_reg)
			RF_IDLE: begin
				low_cnt_next = 6'h00;
				ext_hold_next = 1'b0;
				if (ext_low) begin
					rf_state_next = RF_COUNT;
					low_cnt_next = 6'h01;
				end
			end
			RF_COUNT: begin
				if (!ext_low) begin
					rf_state_next = RF_IDLE;
					low_cnt_next = 6'h00;
				end else if (low_cnt_reg < rst_min_cyc) begin
					low_cnt_next = low_cnt_reg + 6'h01;
				end else begin
					rf_state_next = RF_HOLD;
					ext_hold_next = 1'b1;
				end
			end
			RF_HOLD: begin
				if (!ext_low) begin
					rf_state_next = RF_IDLE;
					low_cnt_next = 6'h00;
					ext_hold_next = 1'b0;
				end
			end
			default: begin
				rf_state_next = RF_IDLE;
				low_cnt_next = 6'h00;
				ext_hold_next = 1'b0;
			end
		endcase
	end

	// ==========================================
	// low-time filter, state registers
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rf_state_reg <= RF_IDLE;
			low_cnt_reg <= 6'h00;
			ext_hold_reg <= 1'b0;
		end else begin
			rf_state_reg <= rf_state_next;
			low_cnt_reg <= low_cnt_next;
			ext_hold_reg <= ext_hold_next;
		end
	end

	// ==========================================
	// a long enough low pin resets even with a stopped clock
	assign bank_rst = i_rst | ~i_ext_rst_n | ext_hold_reg;
	always @(posedge i_mclk or posedge bank_rst) begin
		if (bank_rst) begin
			o_rst_active <= 1'b1;
		end else begin
			o_rst_active <= 1'b0;
		end
	end

	// ==========================================
	// wide ports
	wire [`PIO_WIDE_W*4-1:0] wide_pin_in;
	// gather pin levels, port one lowest
	assign wide_pin_in[7:0] = i_port_one_pins;
	assign wide_pin_in[15:8] = i_port_two_pins;
	assign wide_pin_in[23:16] = i_port_three_pins;
	assign wide_pin_in[31:24] = i_port_four_pins;
	genvar p;
	generate
		for (p = 0; p < 4; p = p + 1) begin : g_port
			wire [`PIO_WIDE_W-1:0] port_dir;
			wire [`PIO_WIDE_W-1:0] port_out;
			wire [`PIO_WIDE_W-1:0] port_pull;
			wire [`PIO_WIDE_W-1:0] port_pin;
			assign port_dir = i_wide_dir[p*8 +: 8];
			assign port_out = i_wide_out[p*8 +: 8];
			assign port_pull = i_wide_pull[p*8 +: 8];
			assign port_pin = wide_pin_in[p*8 +: 8];
			pio_pin_bank #(.W(`PIO_WIDE_W)) u_bank (
				.i_mclk(i_mclk),
				.i_rst(bank_rst),
				.i_wr(i_port_wr[p]),
				.i_dir(port_dir),
				.i_out(port_out),
				.i_pull(port_pull),
				.i_force_mask(`PIO_WIDE_RST),
				.i_force_dir(`PIO_WIDE_RST),
				.o_in(o_wide_in[p*8 +: 8]),
				.i_pin(port_pin),
				.o_pin(o_wide_pins[p*8 +: 8]),
				.o_pin_oe(o_wide_pins_oe[p*8 +: 8]),
				.o_pull_en(o_wide_pull_en[p*8 +: 8])
			);
		end
	endgenerate

	// ==========================================
	// legacy fuse synchroniser, two flops
	reg fuse_s1_reg;
	reg fuse_reg;
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			fuse_s1_reg <= 1'b0;
			fuse_reg <= 1'b0;
		end else begin
			fuse_s1_reg <= i_legacy_compat_fuse;
			fuse_reg <= fuse_s1_reg;
		end
	end

	// ==========================================
	// legacy direction override for the narrow port
	reg [`PIO_NARROW_W-1:0] force_mask;
	reg [`PIO_NARROW_W-1:0] force_dir;
	always @* begin
		force_mask = `PIO_NARROW_RST;
		force_dir = `PIO_NARROW_RST;
		if (fuse_reg) begin
			force_mask = `PIO_LEGACY_DIR_MASK;
			force_dir = `PIO_LEGACY_DIR;
		end
	end

	// ==========================================
	// narrow port
	pio_pin_bank #(.W(`PIO_NARROW_W)) u_narrow (
		.i_mclk(i_mclk),
		.i_rst(bank_rst),
		.i_wr(i_port_wr[4]),
		.i_dir(i_narrow_dir),
		.i_out(i_narrow_port_output),
		.i_pull(i_narrow_pull),
		.i_force_mask(force_mask),
		.i_force_dir(force_dir),
		.o_in(o_narrow_in),
		.i_pin(i_narrow_port_pins),
		.o_pin(o_narrow_port_pins),
		.o_pin_oe(o_narrow_port_pins_oe),
		.o_pull_en(o_narrow_pull_en)
	);
endmodule
`default_nettype wire

// ---- tb/pio_props_properties.sv ----
// pio_props: port checks for pio_top
// assumes: bound into pio_top, one clock
`timescale 1ns/1ps
`default_nettype none
module pio_props (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ext_rst_n,
	input wire logic i_legacy_compat_fuse,
	input wire logic [4:0] i_port_wr,
	input wire logic [31:0] i_wide_dir,
	input wire logic [31:0] i_wide_pull,
	input wire logic [2:0] i_narrow_dir,
	input wire logic o_rst_active,
	input wire logic [31:0] o_wide_pins,
	input wire logic [31:0] o_wide_pins_oe,
	input wire logic [31:0] o_wide_pull_en,
	input wire logic [2:0] o_narrow_port_pins_oe
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst || !i_ext_rst_n);
	// ====
	// checks
	rst_tri_a: assert property (disable iff (1'b0) i_rst || !i_ext_rst_n |->
		~|o_wide_pins_oe && ~|o_narrow_port_pins_oe) else $error("pins driven in reset");
	rst_flag_a: assert property (disable iff (1'b0) !i_ext_rst_n |-> o_rst_active)
		else $error("ext reset not seen");
	wide_dir_a: assert property (i_port_wr[0] |-> ##2 o_wide_pins_oe[7:0] == $past(i_wide_dir[7:0], 2))
		else $error("wide dir wrong");
	narrow_dir_a: assert property (!i_legacy_compat_fuse[*3] ##0 i_port_wr[4] |->
		##2 o_narrow_port_pins_oe == $past(i_narrow_dir, 2)) else $error("narrow dir wrong");
	pull_sel_a: assert property (i_port_wr[1] |-> ##2 o_wide_pull_en[15:8] ==
		($past(i_wide_pull[15:8], 2) & ~o_wide_pins_oe[15:8] & o_wide_pins[15:8])) else $error("pull wrong");
	legacy_dir_a: assert property (i_legacy_compat_fuse[*3] ##0 i_port_wr[4] |->
		##2 o_narrow_port_pins_oe == 3'h6) else $error("legacy dir wrong");
	reset_dflt_a: assert property ($fell(i_rst) |-> ~|o_wide_pins_oe && ~|o_wide_pull_en)
		else $error("not idle after reset");
	cover property (i_port_wr[4] && i_legacy_compat_fuse);
	cover property ($rose(i_ext_rst_n));
	cover property (i_port_wr[0]);
endmodule
bind pio_top pio_props u_props (.*);
`default_nettype wire

// ---- tb/pio_board.sv ----
// pio_board: board side of all 35 pins
// assumes: oe high means the block drives
`timescale 1ns/1ps
`default_nettype none
module pio_board (
	input wire logic [34:0] i_oe,
	input wire logic [34:0] i_o,
	input wire logic [34:0] i_pu,
	input wire logic [34:0] i_ext,
	output logic [34:0] o_pin
);
	// driven bits win, else pull-up or board level
	assign o_pin = (i_oe & i_o) | (~i_oe & (i_pu | i_ext));
endmodule
`default_nettype wire

// ---- tb/tb_parallel_io_ports.sv ----
// tb_parallel_io_ports: bench for pio_top
// assumes: pio_top, pio_board, pio_props compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_io_ports;
	logic clk = 0, rst = 1, xr = 1, fuse = 0;
	logic [4:0] wr = 0;
	logic [31:0] dir = 0, out = 0, pull = 0, oe, o, pu, win;
	logic [2:0] nd = 0, no_v = 0, np = 0, noe, no, npu, nin;
	logic [34:0] ext = 0, pins;
	logic ra;
	int mismatches = 0, n_compared = 0;
	always #20 clk = ~clk;
	pio_top u_dut (.i_mclk(clk), .i_rst(rst), .i_ext_rst_n(xr), .i_legacy_compat_fuse(fuse), .i_port_wr(wr),
		.i_wide_dir(dir), .i_wide_out(out), .i_wide_pull(pull), .i_narrow_dir(nd), .i_narrow_port_output(no_v),
		.i_narrow_pull(np), .o_wide_in(win), .o_narrow_in(nin), .o_rst_active(ra),
		.i_port_one_pins(pins[7:0]), .i_port_two_pins(pins[15:8]), .i_port_three_pins(pins[23:16]),
		.i_port_four_pins(pins[31:24]), .i_narrow_port_pins(pins[34:32]), .o_wide_pins(o),
		.o_wide_pins_oe(oe), .o_wide_pull_en(pu), .o_narrow_port_pins(no), .o_narrow_port_pins_oe(noe),
		.o_narrow_pull_en(npu));
	pio_board u_board (.i_oe({noe, oe}), .i_o({no, o}), .i_pu({npu, pu}), .i_ext(ext), .o_pin(pins));
	// ====
	// helpers
	task automatic chk(input string n, input logic [34:0] e, input logic [34:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic finish_test;
		if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// ====
	// scenarios
	task automatic t_wide;
		dir = 32'hf0f0_33cc;
		out = 32'hff00_aa55;
		pull = 32'h0f0f_ffff;
		ext = 35'h0_0101_0000;
		wr = 5'h0f;
		step(1);
		wr = 5'h00;
		step(2);
		chk("oe", dir, oe);
		chk("pins", out, o);
		chk("pull", ~dir & out & pull, pu);
		step(3);
		chk("in", (dir & out) | (~dir & ((out & pull) | ext[31:0])), win);
		rst = 1;
		#5;
		chk("rst_oe", 35'h0, {noe, oe});
		step(1);
		rst = 0;
		step(1);
		chk("idle", 35'h0, {noe, pu});
	endtask
	task automatic t_narrow;
		for (int f = 0; f < 2; f++) begin
			fuse = f[0];
			nd = 3'h1;
			no_v = 3'h7;
			np = 3'h7;
			step(3);
			wr = 5'h10;
			step(1);
			wr = 5'h00;
			step(2);
			chk("n_oe", f ? 3'h6 : 3'h1, noe);
			chk("n_pins", 3'h7, no);
			chk("n_pull", f ? 3'h1 : 3'h6, npu);
			step(2);
			chk("n_in", 3'h7, nin);
		end
	endtask
	task automatic t_ext;
		xr = 0;
		#5;
		chk("x_oe", 35'h0, {noe, oe});
		step(45);
		chk("x_flag", 35'h1, ra);
		xr = 1;
		step(1);
		chk("x_hold", 35'h1, ra);
		step(4);
		chk("x_rel", 35'h0, ra);
		chk("x_idle", {3'h6, 32'h0}, {noe, oe});
	endtask
	initial begin
		step(10);
		rst = 0;
		step(1);
		t_wide;
		t_narrow;
		t_ext;
		finish_test;
	end
endmodule
`default_nettype wire
